// file: inc/ata_exec_map.svh
// Purpose: Offsets, field positions, codes and reset values of the task-file command executor
// Assumes: Included by the package and by design files; definitions only
// Notes: Register offsets are a byte index on the plain register port
`ifndef ATA_EXEC_MAP_SVH
`define ATA_EXEC_MAP_SVH

`define REG_DATA_ERR 3'h1
`define REG_SECTOR_COUNT 3'h2
`define REG_SECTOR_NUMBER 3'h3
`define REG_CYL_LOW 3'h4
`define REG_CYL_HIGH 3'h5
`define REG_DRIVE_HEAD 3'h6
`define REG_CMD_STATUS 3'h7

`define ST_BSY 7
`define ST_DRDY 6
`define ST_DSC 4
`define ST_ERR 0
`define ER_IDNF 4
`define ER_ABRT 2
`define DH_LBA 6

`define OP_SEEK_NIB 4'h7
`define OP_SET_FEATURES 8'hef

`define FC_8BIT_ON 8'h01
`define FC_NOP_A 8'h44
`define FC_NOP_B 8'h55
`define FC_KEEP_ON_RESET 8'h66
`define FC_NOP_C 8'h69
`define FC_8BIT_OFF 8'h81
`define FC_NOP_D 8'h96
`define FC_CLOCK 8'h97
`define FC_CURRENT 8'h9a
`define FC_NOP_E 8'haa
`define FC_NOP_F 8'hbb
`define FC_RESTORE_ON_RESET 8'hcc

`define RST_STATUS 8'h50
`define RST_CLOCK 8'h0f
`define RST_CURRENT 8'hff
`define CUR_MAX_DIV4 8'h08
`define CUR_MIN_DIV4 8'h02
`define DEF_HEADS 4'hf
`define DEF_CYLS 16'h0800
`define DEF_LBA_LIMIT 28'h0200000
`define EXEC_CYCLES 4'h3

`endif

// file: inc/ata_exec_pkg.sv
// Purpose: Types shared by the task-file command executor
// Assumes: Map header holds all numbers
// Notes: None
`include "ata_exec_map.svh"
package ata_exec_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} bus_req_type;

	typedef struct packed {
		logic eightBit;
		logic keepOnReset;
		logic powerByCurrent;
		logic [7:0] clockSetting;
		logic [7:0] currentSetting;
	} feature_type;

	typedef enum logic [1:0] {
		IDLE,
		RUN,
		DONE
	} exec_state_type;
endpackage : ata_exec_pkg

// file: core/ata_range_check.sv
// Purpose: Bounds check of a seek target in CHS or LBA form
// Assumes: Limits are steady inputs
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module ata_range_check (
	input wire logic lbaMode, // Target given as LBA
	input wire logic [3:0] head, // Head or LBA 27:24
	input wire logic [7:0] cylHigh, // Cylinder high or LBA 23:16
	input wire logic [7:0] cylLow, // Cylinder low or LBA 15:8
	input wire logic [7:0] sectorNum, // LBA 7:0
	input wire logic [3:0] maxHead, // Highest valid head
	input wire logic [15:0] cylCount, // Number of cylinders
	input wire logic [27:0] lbaLimit, // Number of LBAs
	output logic outOfRange // Target outside the media
);
	logic [27:0] lba;

	always_comb begin
		lba = {head, cylHigh, cylLow, sectorNum};
		if (lbaMode)
			outOfRange = (lba >= lbaLimit);
		else
			outOfRange = (head > maxHead) || ({cylHigh, cylLow} >= cylCount);
	end
endmodule : ata_range_check
`default_nettype wire

// file: core/ata_seek_set_features_exec.sv
// Purpose: Executes Seek and Set Features from the task file
// Assumes: Host register port on mclk; soft reset is a one-cycle pulse from the same clock
// Notes: Opcodes other than Seek and Set Features are left to other logic
`timescale 1ns/100ps
`default_nettype none
`include "ata_exec_map.svh"
module ata_seek_set_features_exec
	import ata_exec_pkg::*;
(
	input wire logic mclk, // System clock, 50 MHz
	input wire logic reset_n, // Asynchronous power-on reset
	input wire logic softReset, // Host soft reset pulse
	input wire logic [2:0] addr, // Task-file register index
	input wire logic [7:0] wdata, // Write data
	input wire logic write, // Write strobe
	input wire logic read, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after read
	output logic busy, // Command executing
	output logic eightBitMode, // 8-bit host data transfers on
	output logic [7:0] clockSetting, // Internal clock code
	output logic [7:0] currentSetting, // Current limit, mA/4
	output logic powerByCurrent // Power set by current control
);
	bus_req_type req;
	exec_state_type state, next_state;
	feature_type feat, next_feat;
	logic [7:0] status, next_status;
	logic [7:0] errorReg, next_errorReg;
	logic [7:0] featureReg, next_featureReg;
	logic [7:0] sectorCount, next_sectorCount;
	logic [7:0] sectorNum, next_sectorNum;
	logic [7:0] cylLow, next_cylLow;
	logic [7:0] cylHigh, next_cylHigh;
	logic [7:0] driveHead, next_driveHead;
	logic [7:0] opcode, next_opcode;
	logic [3:0] count, next_count;
	logic [7:0] next_rdata;
	logic outOfRange;
	logic isSeek;
	logic isSetFeatures;

	assign req = '{addr: addr, wdata: wdata, write: write, read: read};
	assign isSeek = (req.wdata[7:4] == `OP_SEEK_NIB);
	assign isSetFeatures = (req.wdata == `OP_SET_FEATURES);

	ata_range_check u_range (
		.lbaMode(driveHead[`DH_LBA]),
		.head(driveHead[3:0]),
		.cylHigh(cylHigh),
		.cylLow(cylLow),
		.sectorNum(sectorNum),
		.maxHead(`DEF_HEADS),
		.cylCount(`DEF_CYLS),
		.lbaLimit(`DEF_LBA_LIMIT),
		.outOfRange(outOfRange)
	);

	always_comb begin
		next_state = state;
		next_feat = feat;
		next_status = status;
		next_errorReg = errorReg;
		next_featureReg = featureReg;
		next_sectorCount = sectorCount;
		next_sectorNum = sectorNum;
		next_cylLow = cylLow;
		next_cylHigh = cylHigh;
		next_driveHead = driveHead;
		next_opcode = opcode;
		next_count = count;
		// Task-file writes are ignored while busy, as on a real drive
		if (req.write && state == IDLE) begin
			case (req.addr)
				`REG_DATA_ERR: next_featureReg = req.wdata;
				`REG_SECTOR_COUNT: next_sectorCount = req.wdata;
				`REG_SECTOR_NUMBER: next_sectorNum = req.wdata;
				`REG_CYL_LOW: next_cylLow = req.wdata;
				`REG_CYL_HIGH: next_cylHigh = req.wdata;
				`REG_DRIVE_HEAD: next_driveHead = req.wdata;
				`REG_CMD_STATUS: begin
					if (isSeek || isSetFeatures) begin
						next_opcode = req.wdata;
						next_status = 8'h00;
						next_status[`ST_BSY] = 1'b1;
						next_count = `EXEC_CYCLES;
						next_state = RUN;
					end
				end
				default: ;
			endcase
		end
		case (state)
			IDLE: ;
			RUN: begin
				if (count != 4'h0)
					next_count = count - 4'h1;
				else begin
					next_errorReg = 8'h00;
					next_status = 8'h00;
					next_status[`ST_BSY] = 1'b1;
					if (opcode[7:4] == `OP_SEEK_NIB) begin
						next_errorReg[`ER_IDNF] = outOfRange;
					end else begin
						case (featureReg)
							`FC_8BIT_ON: next_feat.eightBit = 1'b1;
							`FC_8BIT_OFF: next_feat.eightBit = 1'b0;
							`FC_NOP_A, `FC_NOP_B, `FC_NOP_C: ;
							`FC_NOP_D, `FC_NOP_E, `FC_NOP_F: ;
							`FC_KEEP_ON_RESET: next_feat.keepOnReset = 1'b1;
							`FC_RESTORE_ON_RESET: next_feat.keepOnReset = 1'b0;
							`FC_CLOCK: begin
								next_feat.clockSetting = sectorCount;
								next_feat.powerByCurrent = 1'b0;
							end
							`FC_CURRENT: begin
								next_feat.currentSetting = sectorCount;
								next_feat.powerByCurrent = 1'b1;
								next_cylHigh = `CUR_MAX_DIV4;
								next_cylLow = `CUR_MIN_DIV4;
							end
							default: next_errorReg[`ER_ABRT] = 1'b1;
						endcase
					end
					next_state = DONE;
				end
			end
			DONE: begin
				// Results settled a cycle earlier, so BSY drops last
				next_status = 8'h00;
				next_status[`ST_DRDY] = 1'b1;
				next_status[`ST_DSC] = 1'b1;
				next_status[`ST_ERR] = errorReg[`ER_ABRT];
				next_state = IDLE;
			end
			default: next_state = IDLE;
		endcase
		if (softReset) begin
			next_state = IDLE;
			next_status = `RST_STATUS;
			next_errorReg = 8'h00;
			next_count = 4'h0;
			if (!feat.keepOnReset) begin
				next_feat.eightBit = 1'b0;
				next_feat.powerByCurrent = 1'b0;
				next_feat.clockSetting = `RST_CLOCK;
				next_feat.currentSetting = `RST_CURRENT;
			end
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (req.read) begin
			case (req.addr)
				`REG_DATA_ERR: next_rdata = errorReg;
				`REG_SECTOR_COUNT: next_rdata = sectorCount;
				`REG_SECTOR_NUMBER: next_rdata = sectorNum;
				`REG_CYL_LOW: next_rdata = cylLow;
				`REG_CYL_HIGH: next_rdata = cylHigh;
				`REG_DRIVE_HEAD: next_rdata = driveHead;
				`REG_CMD_STATUS: next_rdata = status;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= IDLE;
			feat <= '{eightBit: 1'b0, keepOnReset: 1'b0, powerByCurrent: 1'b0,
				clockSetting: `RST_CLOCK, currentSetting: `RST_CURRENT};
			status <= `RST_STATUS;
			errorReg <= 8'h00;
			featureReg <= 8'h00;
			sectorCount <= 8'h00;
			sectorNum <= 8'h00;
			cylLow <= 8'h00;
			cylHigh <= 8'h00;
			driveHead <= 8'h00;
			opcode <= 8'h00;
			count <= 4'h0;
			rdata <= 8'h00;
		end else begin
			state <= next_state;
			feat <= next_feat;
			status <= next_status;
			errorReg <= next_errorReg;
			featureReg <= next_featureReg;
			sectorCount <= next_sectorCount;
			sectorNum <= next_sectorNum;
			cylLow <= next_cylLow;
			cylHigh <= next_cylHigh;
			driveHead <= next_driveHead;
			opcode <= next_opcode;
			count <= next_count;
			rdata <= next_rdata;
		end
	end

	assign busy = status[`ST_BSY];
	assign eightBitMode = feat.eightBit;
	assign clockSetting = feat.clockSetting;
	assign currentSetting = feat.currentSetting;
	assign powerByCurrent = feat.powerByCurrent;
endmodule : ata_seek_set_features_exec
`default_nettype wire

// file: tb/ata_exec_checker.sv
// Purpose: Port assertions of the command executor
// Assumes: One clock; no soft reset while busy
// Notes: Tracks the last feature code and opcode itself
`timescale 1ns/100ps
`default_nettype none
module ata_exec_checker (
	input wire logic mclk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [2:0] addr, // Index
	input wire logic [7:0] wdata, // Write data
	input wire logic write, // Write strobe
	input wire logic read, // Read strobe
	input wire logic [7:0] rdata, // Read data
	input wire logic busy, // Executing
	input wire logic eightBitMode, // 8-bit mode
	input wire logic powerByCurrent // Power by current
);
	logic [7:0] feat;
	logic [7:0] op;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			feat <= 8'h00;
			op <= 8'h00;
		end else if (write && !busy && addr == 3'h1) begin
			feat <= wdata;
		end else if (write && !busy && addr == 3'h7) begin
			op <= wdata;
		end
	end
	// Completion cycle still shows busy; the past term also skips the first idle cycle, where writes are taken
	cmd_start_a: assert property (write && addr == 3'h7 && wdata == 8'hef && !busy && !$past(busy) |=> busy)
		else $error("busy did not rise");
	busy_span_a: assert property ($rose(busy) |-> busy [*5] ##1 !busy)
		else $error("busy length wrong");
	busy_status_a: assert property (read && addr == 3'h7 && busy |=> rdata == 8'h80)
		else $error("status while busy wrong");
	eight_on_a: assert property ($fell(busy) && op == 8'hef && feat == 8'h01 |-> eightBitMode)
		else $error("8-bit mode not on");
	eight_off_a: assert property ($fell(busy) && op == 8'hef && feat == 8'h81 |-> !eightBitMode)
		else $error("8-bit mode not off");
	by_current_a: assert property ($fell(busy) && op == 8'hef && feat == 8'h9a |-> powerByCurrent)
		else $error("current control not taken");
	by_clock_a: assert property ($fell(busy) && op == 8'hef && feat == 8'h97 |-> !powerByCurrent)
		else $error("clock control not taken");
	nop_keep_a: assert property ($fell(busy) && op == 8'hef && (feat == 8'h44 || feat == 8'h55 || feat == 8'h69)
		|-> eightBitMode == $past(eightBitMode, 6) && powerByCurrent == $past(powerByCurrent, 6))
		else $error("no-operation code changed a setting");
	seek_keep_a: assert property ($fell(busy) && op[7:4] == 4'h7 |-> eightBitMode == $past(eightBitMode, 6))
		else $error("seek changed a setting");
	cover property ($rose(busy));
	cover property ($fell(busy) && op == 8'hef && feat == 8'h9a);
	cover property (read && busy);
endmodule : ata_exec_checker
`default_nettype wire

// file: tb/ata_host_model.sv
// Purpose: Host side of the task-file register port
// Assumes: Slave never stalls
// Notes: Released write data is inverted, never stale
`timescale 1ns/100ps
`default_nettype none
module ata_host_model (
	input wire logic mclk, // Clock
	input wire logic [7:0] rdata, // Read data
	output logic [2:0] addr = 3'h0, // Index
	output logic [7:0] wdata = 8'h00, // Write data
	output logic write = 1'b0, // Write strobe
	output logic read = 1'b0 // Read strobe
);
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge mclk);
		write <= 1'b0;
		wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		read <= 1'b1;
		@(posedge mclk);
		read <= 1'b0;
		#1;
		d = rdata;
	endtask : rd
	// Parameters first, opcode last
	task automatic issue(input logic [79:0] row);
		for (int i = 1; i < 7; i++) wr(i[2:0], row[79 - 8 * i -: 8]);
		wr(3'h7, row[79:72]);
	endtask : issue
endmodule : ata_host_model
`default_nettype wire

// file: tb/tb_ata_seek_set_features_exec.sv
// Purpose: Self-checking bench of the command executor
// Assumes: Row = opcode, regs 1..6, status, error, mode bits
// Notes: Soft reset cases follow the table
`timescale 1ns/100ps
`default_nettype none
module tb_ata_seek_set_features_exec;
	import ata_exec_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic softReset = 1'b0;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, clockSetting, currentSetting, d;
	logic write, read, busy, eightBitMode, powerByCurrent;
	int fail_count = 0;
	int samples_checked = 0;
	logic [79:0] rows [14] = '{80'hef01_0000_0000_0050_0002, 80'hef44_0000_0000_0050_0002,
		80'hef55_0000_0000_0050_0002, 80'hef69_0000_0000_0050_0002, 80'hef96_0000_0000_0050_0002,
		80'hefaa_0000_0000_0050_0002, 80'hefbb_0000_0000_0050_0002, 80'hef81_0000_0000_0050_0000,
		80'hef9a_0600_0000_0050_0001, 80'hef97_0a00_0000_0050_0000, 80'hef02_0000_0000_0051_0400,
		80'h7000_0000_0103_0050_0000, 80'h7f00_0000_0008_0050_1000, 80'h7000_00ff_ff1f_4050_0000};
	always #10 mclk = ~mclk;
	ata_host_model host (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .write(write), .read(read));
	ata_seek_set_features_exec dut (.mclk(mclk), .reset_n(reset_n), .softReset(softReset), .addr(addr),
		.wdata(wdata), .write(write), .read(read), .rdata(rdata), .busy(busy), .eightBitMode(eightBitMode),
		.clockSetting(clockSetting), .currentSetting(currentSetting), .powerByCurrent(powerByCurrent));
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check8
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic run(input logic [79:0] row);
		int n;
		n = 0;
		host.issue(row);
		host.rd(3'h7, d);
		check8("busy status", 8'h80, d);
		while (busy !== 1'b0) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 20) begin
				fail_count++;
				stop_test();
			end
		end
		@(posedge mclk);
		host.rd(3'h7, d);
		check8("status", row[23:16], d);
		host.rd(3'h1, d);
		check8("error", row[15:8], d);
		check8("mode", row[7:0], {6'h00, eightBitMode, powerByCurrent});
		if (row[79:64] == 16'hef9a) begin
			host.rd(3'h5, d);
			check8("cyl high", 8'h08, d);
			host.rd(3'h4, d);
			check8("cyl low", 8'h02, d);
			check8("current", row[63:56], currentSetting);
		end
		if (row[79:64] == 16'hef97) check8("clock", row[63:56], clockSetting);
	endtask : run
	task automatic pulse();
		@(posedge mclk);
		softReset <= 1'b1;
		@(posedge mclk);
		softReset <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : pulse
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		host.rd(3'h7, d);
		check8("reset status", 8'h50, d);
		check8("reset mode", 8'h00, {7'h00, eightBitMode});
		check8("reset clock", 8'h0f, clockSetting);
		check8("reset current", 8'hff, currentSetting);
		foreach (rows[i]) run(rows[i]);
		run(80'h7000_0000_0020_4050_1000);
		run(rows[0]);
		pulse();
		check8("restored mode", 8'h00, {7'h00, eightBitMode});
		check8("restored clock", 8'h0f, clockSetting);
		check8("restored current", 8'hff, currentSetting);
		run(80'hef66_0000_0000_0050_0000);
		run(rows[0]);
		pulse();
		check8("kept mode", 8'h01, {7'h00, eightBitMode});
		run(80'hefcc_0000_0000_0050_0002);
		pulse();
		check8("mode after cc", 8'h00, {7'h00, eightBitMode});
		stop_test();
	end
endmodule : tb_ata_seek_set_features_exec
bind ata_seek_set_features_exec ata_exec_checker chk (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
	.write(write), .read(read), .rdata(rdata), .busy(busy), .eightBitMode(eightBitMode), .powerByCurrent(powerByCurrent));
`default_nettype wire
